// >>> hw/isa_mode_pkg.sv
// Package: constants and carrier types for the instruction-set mode controller
package isa_mode_pkg;

  // ==========================================================================
  // Register map (byte addresses on the AXI4-Lite slave)
  localparam logic [7:0] CFG_ADDR      = 8'h00;  // Configuration: encodings and entry mode
  localparam logic [7:0] DBG_CTRL_ADDR = 8'h04;  // Test-port control: debug entry mode
  localparam logic [7:0] STATUS_ADDR   = 8'h08;  // Privileged status view of the block

  // ==========================================================================
  // Field positions
  localparam int ENC_LSB      = 14;  // Available encodings, bits 15:14
  localparam int ENC_MSB      = 15;
  localparam int EXC_MODE_BIT = 16;  // Exception entry mode choice
  localparam int DBG_MODE_BIT = 0;   // Debug entry mode choice in test-port control

  // ==========================================================================
  // Encoding availability codes and mode values
  localparam logic [1:0] ENC_FIXED_ONLY   = 2'h0;
  localparam logic [1:0] ENC_COMPACT_ONLY = 2'h1;
  localparam logic [1:0] ENC_BOTH_FIXED   = 2'h2;  // Both, reset into fixed mode
  localparam logic [1:0] ENC_BOTH_COMPACT = 2'h3;  // Both, reset into compact mode
  localparam logic       MODE_FIXED       = 1'h0;
  localparam logic       MODE_COMPACT     = 1'h1;

  // ==========================================================================
  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Kind of a retiring control-flow event
  typedef enum logic [2:0] {
    EV_NONE      = 3'b000,
    EV_JR        = 3'b001,  // Register-indirect jump
    EV_INDIRECT_JUMP_LINK      = 3'b010,  // Register-indirect jump and link
    EV_EXCHANGE_JUMP_LINK      = 3'b011,  // Mode-exchanging absolute jump and link
    EV_EXC       = 3'b100,  // Exception via exception vector base
    EV_DBG       = 3'b101,  // Debug exception
    EV_ERR       = 3'b110,  // Error exception (reset class)
    EV_RET       = 3'b111   // Exception return
  } event_kind_t;

  // Event carrier from the pipeline
  typedef struct packed {
    logic        valid;
    event_kind_t kind;
    logic [1:0]  elem;      // Virtual processing element index
    logic [31:0] src;       // Source register or return register value
  } flow_event_t;

  // Results returned to the pipeline
  typedef struct packed {
    logic        pc_valid;
    logic [31:0] pc;          // Target with bit 0 cleared
    logic        link_valid;
    logic        link_bit0;   // Mode to place in bit 0 of link register
    logic        save_valid;
    logic        save_bit0;   // Mode to place in bit 0 of the return register
    logic        resv_instr;  // Reserved instruction exception request
    logic        addr_exc;    // Address exception on target fetch
  } flow_result_t;

endpackage : isa_mode_pkg

// >>> hw/isa_mode_switch_control.sv
// Instruction-set mode controller with configuration registers on AXI4-Lite
//
// Functional notes
// RULE_01: Hold one mode bit; 0 fixed decoding, 1 compact decoding.
// RULE_02: Mode not readable by user software; only trace is return bit 0.
// RULE_03: Read-only field at bits 15:14 reports available encodings.
// RULE_04: Dual core reset mode follows external available-encoding field.
// RULE_05: Bit 16 chooses mode adopted on exception entry.
// RULE_06: Exception-entry mode writable by privileged software, reset from strap.
// RULE_07: Entry choice applies to all vector-base-offset exceptions.
// RULE_08: Debug-entry mode in test-port control, probe writable, strap reset.
// RULE_09: Exception-entry mode kept separately per virtual processing element.
// RULE_10: Compact mode treats listed indirect jump variants as link/non-link classes.
// RULE_11: Indirect jumps take source bit 0 as new mode.
// RULE_12: Indirect jump target is source with bit 0 cleared.
// RULE_13: Indirect jump-and-link writes current mode to link bit 0.
// RULE_14: Exchange jump-and-link does absolute jump-link and inverts mode.
// RULE_15: Exception entry saves mode to return bit 0, then sets entry mode.
// RULE_16: Exception return restores mode from return register bit 0.
// RULE_17: Single-encoding core keeps fixed mode bit, no switching.
// RULE_18: Single-encoding core: exchange jump-link raises reserved instruction.
// RULE_19: Single-encoding core: mismatched jump bit 0 raises address exception.
// RULE_20: Single-encoding core: indirect link still writes fixed mode.
// RULE_21: Compact set and old compression extension never coexist.
// RULE_22: Compact encoding has no branch-likely instructions.
// RULE_23: Compact encoding keeps delay-slot execution.
// RULE_24: Compact offsets shift left one bit; fixed shift two.
// RULE_25: First handler instruction decodes in the new entry mode.
`timescale 1ns/100ps

module isa_mode_switch_control #(
  parameter int NUM_ELEM = 4
) (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // External configuration straps (asynchronous to the core)
  input  wire logic [1:0]                 enc_strap,
  input  wire logic                       exc_mode_strap,
  input  wire logic                       dbg_mode_strap,
  // Debug probe write of the debug entry mode
  input  wire logic                       probe_wr,
  input  wire logic                       probe_mode,
  // Pipeline event and results
  input  wire isa_mode_pkg::flow_event_t  flow_event,
  input  wire logic                       branch_likely,
  input  wire logic [25:0]                offset,
  output logic                            cur_mode,
  output isa_mode_pkg::flow_result_t      flow_result,
  output logic                            illegal_likely,
  output logic [31:0]                     offset_bytes,
  output logic                            compression_ext_present_bit,
  // AXI4-Lite slave
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready
);

  // ==========================================================================
  // State record
  typedef struct packed {
    logic [1:0]                 enc_s1;
    logic [1:0]                 enc_s2;
    logic                       exc_s1;
    logic                       exc_s2;
    logic                       dbg_s1;
    logic                       dbg_s2;
    logic                       init;          // Straps captured after reset release
    logic [1:0]                 available_encoding_field;
    logic [NUM_ELEM-1:0]        exc_entry_mode_field;
    logic                       debug_entry_mode_sel;
    logic                       mode;
    logic [1:0]                 last_elem;
    isa_mode_pkg::flow_result_t res;
    logic                       aw_held;
    logic [7:0]                 aw_addr;
    logic                       w_held;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       bvalid;
    logic [1:0]                 bresp;
    logic                       rvalid;
    logic [31:0]                rdata;
    logic [1:0]                 rresp;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Whether both encodings exist
  function automatic logic dual_enc(input logic [1:0] enc);
    dual_enc = enc[1];
  endfunction : dual_enc

  // Fixed mode of a single-encoding core
  function automatic logic fixed_mode(input logic [1:0] enc);
    fixed_mode = (enc == isa_mode_pkg::ENC_COMPACT_ONLY);
  endfunction : fixed_mode

  logic [1:0] elem_idx;
  logic       wr_fire;
  logic       rd_fire;
  logic [31:0] cfg_word;

  assign elem_idx = flow_event.elem;
  assign wr_fire  = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
  assign rd_fire  = s_axi_arvalid && !state_reg.rvalid;

  // Configuration word seen by privileged software for the last element
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[isa_mode_pkg::ENC_MSB:isa_mode_pkg::ENC_LSB] =
      state_reg.available_encoding_field;                                  // RULE_03
    cfg_word[isa_mode_pkg::EXC_MODE_BIT] =
      state_reg.exc_entry_mode_field[state_reg.last_elem];
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    // Two-flop synchronisers on the straps
    state_next.enc_s1 = enc_strap;
    state_next.enc_s2 = state_reg.enc_s1;
    state_next.exc_s1 = exc_mode_strap;
    state_next.exc_s2 = state_reg.exc_s1;
    state_next.dbg_s1 = dbg_mode_strap;
    state_next.dbg_s2 = state_reg.dbg_s1;
    state_next.res    = '0;

    if (!state_reg.init) begin
      // Straps are sampled once after release; the pipeline must wait for it
      state_next.init                     = 1'b1;
      state_next.available_encoding_field = state_reg.enc_s2;
      state_next.exc_entry_mode_field     = {NUM_ELEM{state_reg.exc_s2}};  // RULE_06 RULE_09
      state_next.debug_entry_mode_sel     = state_reg.dbg_s2;              // RULE_08
      state_next.mode = dual_enc(state_reg.enc_s2) ? state_reg.enc_s2[0]   // RULE_04
                                                   : fixed_mode(state_reg.enc_s2); // RULE_17
    end else if (flow_event.valid) begin
      state_next.last_elem = elem_idx;
      unique case (flow_event.kind)
        isa_mode_pkg::EV_JR, isa_mode_pkg::EV_INDIRECT_JUMP_LINK: begin
          // All listed compact variants arrive already classed as JR or INDIRECT_JUMP_LINK  // RULE_10
          state_next.res.pc_valid = 1'b1;
          state_next.res.pc       = {flow_event.src[31:1], 1'b0};          // RULE_12
          if (flow_event.kind == isa_mode_pkg::EV_INDIRECT_JUMP_LINK) begin
            state_next.res.link_valid = 1'b1;
            state_next.res.link_bit0  = state_reg.mode;                     // RULE_13 RULE_20
          end
          if (dual_enc(state_reg.available_encoding_field))
            state_next.mode = flow_event.src[0];                            // RULE_11
          else
            state_next.res.addr_exc = (flow_event.src[0] != state_reg.mode); // RULE_19
        end
        isa_mode_pkg::EV_EXCHANGE_JUMP_LINK: begin
          if (dual_enc(state_reg.available_encoding_field)) begin
            state_next.res.link_valid = 1'b1;
            state_next.res.link_bit0  = state_reg.mode;
            state_next.mode           = ~state_reg.mode;                    // RULE_14
          end else begin
            state_next.res.resv_instr = 1'b1;                               // RULE_18
          end
        end
        isa_mode_pkg::EV_EXC, isa_mode_pkg::EV_ERR, isa_mode_pkg::EV_DBG: begin
          state_next.res.save_valid = 1'b1;
          state_next.res.save_bit0  = state_reg.mode;                       // RULE_15 RULE_02
          if (dual_enc(state_reg.available_encoding_field)) begin
            // Mode updates with the vector so the handler's first fetch uses it  // RULE_25
            if (flow_event.kind == isa_mode_pkg::EV_DBG)
              state_next.mode = state_reg.debug_entry_mode_sel;             // RULE_08
            else
              state_next.mode = state_reg.exc_entry_mode_field[elem_idx];   // RULE_05 RULE_07 RULE_09
          end
        end
        isa_mode_pkg::EV_RET: begin
          if (dual_enc(state_reg.available_encoding_field))
            state_next.mode = flow_event.src[0];                            // RULE_16
        end
        isa_mode_pkg::EV_NONE: begin
        end
      endcase
    end

    // Debug probe write of the debug entry mode
    if (state_reg.init && probe_wr)
      state_next.debug_entry_mode_sel = probe_mode;                          // RULE_08

    // AXI write channel capture
    if (s_axi_awvalid && !state_reg.aw_held) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_reg.w_held) begin
      state_next.w_held = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = isa_mode_pkg::RESP_OKAY;
      unique case (state_reg.aw_addr)
        isa_mode_pkg::CFG_ADDR: begin
          // Encoding field is read-only; entry mode bit writable on dual-encoding cores only          // RULE_06
          if (state_reg.w_strb[2] && dual_enc(state_reg.available_encoding_field))
            state_next.exc_entry_mode_field[state_reg.last_elem] =
              state_reg.w_data[isa_mode_pkg::EXC_MODE_BIT];                 // RULE_09
        end
        isa_mode_pkg::DBG_CTRL_ADDR: begin
          if (state_reg.w_strb[0] && !(state_reg.init && probe_wr))
            state_next.debug_entry_mode_sel =
              state_reg.w_data[isa_mode_pkg::DBG_MODE_BIT];
        end
        isa_mode_pkg::STATUS_ADDR: begin
        end
        default: state_next.bresp = isa_mode_pkg::RESP_SLVERR;
      endcase
    end
    if (state_reg.bvalid && s_axi_bready)
      state_next.bvalid = 1'b0;

    // AXI read channel
    if (rd_fire) begin
      state_next.rvalid = 1'b1;
      state_next.rresp  = isa_mode_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        isa_mode_pkg::CFG_ADDR:      state_next.rdata = cfg_word;
        isa_mode_pkg::DBG_CTRL_ADDR: state_next.rdata = {31'h0, state_reg.debug_entry_mode_sel};
        isa_mode_pkg::STATUS_ADDR:   state_next.rdata = {30'h0, state_reg.last_elem};
        default: begin
          state_next.rdata = 32'h0000_0000;
          state_next.rresp = isa_mode_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.rvalid && s_axi_rready)
      state_next.rvalid = 1'b0;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      // Strap synchronisers run through reset
      state_reg[$bits(state_t)-1-:8] <= state_next[$bits(state_t)-1-:8];
    end else
      state_reg <= state_next;
  end

  // ==========================================================================
  // Outputs
  assign cur_mode     = state_reg.mode;                                      // RULE_01
  assign flow_result  = state_reg.res;
  // Branch-likely forms do not exist in compact decoding
  assign illegal_likely = branch_likely && state_reg.mode;                   // RULE_22
  // Delay slots unchanged in both modes; only offset scaling differs
  assign offset_bytes = state_reg.mode ? {{5{offset[25]}}, offset, 1'b0}     // RULE_24 RULE_23
                                       : {{4{offset[25]}}, offset, 2'b00};
  // Old compression extension is never built alongside compact decoding
  assign compression_ext_present_bit = 1'b0;                                 // RULE_21
  assign s_axi_awready = !state_reg.aw_held;
  assign s_axi_wready  = !state_reg.w_held;
  assign s_axi_bvalid  = state_reg.bvalid;
  assign s_axi_bresp   = state_reg.bresp;
  assign s_axi_arready = !state_reg.rvalid;
  assign s_axi_rvalid  = state_reg.rvalid;
  assign s_axi_rdata   = state_reg.rdata;
  assign s_axi_rresp   = state_reg.rresp;

endmodule : isa_mode_switch_control

// >>> tb/strap_probe_model.sv
// Far-side model: configuration straps and debug probe driving the mode controller
`timescale 1ns/100ps

module strap_probe_model (
  // Clock
  input  wire logic aclk,
  // Straps and probe write
  output logic [1:0] enc_strap,
  output logic       exc_mode_strap,
  output logic       dbg_mode_strap,
  output logic       probe_wr,
  output logic       probe_mode
);
  // ==========================================================================
  // Straps are levels that only move while the core sits in reset
  initial begin
    enc_strap = 2'h2;
    exc_mode_strap = 1'b0;
    dbg_mode_strap = 1'b0;
    probe_wr = 1'b0;
    probe_mode = 1'b0;
  end

  task automatic set_straps(input logic [1:0] e, input logic x, input logic d);
    enc_strap <= e;
    exc_mode_strap <= x;
    dbg_mode_strap <= d;
  endtask : set_straps

  // One-cycle probe write; data flips once released so stale values never pass
  task automatic probe_write(input logic v);
    @(posedge aclk);
    probe_wr <= 1'b1;
    probe_mode <= v;
    @(posedge aclk);
    probe_wr <= 1'b0;
    probe_mode <= !v;
  endtask : probe_write
endmodule : strap_probe_model

// >>> tb/isa_mode_chk.sv
// Concurrent checks on the ports of the mode controller
`timescale 1ns/100ps

module isa_mode_chk (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Watched ports
  input wire logic [1:0]                 enc_strap,
  input wire isa_mode_pkg::flow_event_t  flow_event,
  input wire logic                       branch_likely,
  input wire logic [25:0]                offset,
  input wire logic                       cur_mode,
  input wire isa_mode_pkg::flow_result_t flow_result,
  input wire logic                       illegal_likely,
  input wire logic [31:0]                offset_bytes,
  input wire logic                       compression_ext_present_bit
);
  logic [1:0] up_reg;
  logic       live, dual, is_ind, is_indirect_jump_link, is_exchange_jump_link, is_entry, is_ret, src0;

  // ==========================================================================
  // Events count only from the third edge after release, two edges after the straps are loaded
  always_ff @(posedge aclk) begin
    if (!aresetn) up_reg <= 2'h0;
    else if (up_reg != 2'h3) up_reg <= up_reg + 2'h1;
  end

  // Event decode shared by the properties
  always_comb begin
    live = up_reg[1] && flow_event.valid;
    dual = enc_strap[1];
    src0 = flow_event.src[0];
    is_indirect_jump_link = live && flow_event.kind == isa_mode_pkg::EV_INDIRECT_JUMP_LINK;
    is_ind = is_indirect_jump_link || (live && flow_event.kind == isa_mode_pkg::EV_JR);
    is_exchange_jump_link = live && flow_event.kind == isa_mode_pkg::EV_EXCHANGE_JUMP_LINK;
    is_ret = live && flow_event.kind == isa_mode_pkg::EV_RET;
    is_entry = live && flow_event.kind[2] && flow_event.kind != isa_mode_pkg::EV_RET;
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_jump_ok;
    is_ind ##0 (dual || src0 == cur_mode);
  endsequence
  sequence s_jump_bad;
    is_ind ##0 (!dual && src0 != cur_mode);
  endsequence

  property p_ind_mode;
    is_ind && dual |=> cur_mode == $past(src0);
  endproperty
  property p_ind_pc;
    s_jump_ok |=> flow_result.pc_valid && flow_result.pc == ($past(flow_event.src) & 32'hFFFFFFFE);
  endproperty
  property p_link;
    s_jump_ok ##0 is_indirect_jump_link |=> flow_result.link_valid && flow_result.link_bit0 == $past(cur_mode);
  endproperty
  property p_exchange;
    is_exchange_jump_link && dual |=> cur_mode != $past(cur_mode);
  endproperty
  property p_entry_save;
    is_entry |=> flow_result.save_valid && flow_result.save_bit0 == $past(cur_mode);
  endproperty
  property p_return;
    is_ret && dual |=> cur_mode == $past(src0);
  endproperty
  property p_fixed;
    up_reg[1] && !dual |-> cur_mode == (enc_strap == isa_mode_pkg::ENC_COMPACT_ONLY);
  endproperty
  property p_resv;
    is_exchange_jump_link && !dual |=> flow_result.resv_instr && $stable(cur_mode);
  endproperty
  property p_addr;
    s_jump_bad |=> flow_result.addr_exc && $stable(cur_mode);
  endproperty
  property p_likely;
    illegal_likely == (branch_likely && cur_mode);
  endproperty
  property p_offset;
    offset_bytes == (cur_mode ? {{5{offset[25]}}, offset, 1'b0} : {{4{offset[25]}}, offset, 2'b00});
  endproperty
  property p_no_ext;
    compression_ext_present_bit == 1'b0;
  endproperty

  a_ind_mode: assert property (p_ind_mode) else $error("jump mode wrong");
  a_ind_pc: assert property (p_ind_pc) else $error("jump target wrong");
  a_link: assert property (p_link) else $error("link bit wrong");
  a_exchange: assert property (p_exchange) else $error("exchange kept mode");
  a_entry_save: assert property (p_entry_save) else $error("entry save wrong");
  a_return: assert property (p_return) else $error("return mode wrong");
  a_fixed: assert property (p_fixed) else $error("fixed mode moved");
  a_resv: assert property (p_resv) else $error("exchange not refused");
  a_addr: assert property (p_addr) else $error("address fault missing");
  a_likely: assert property (p_likely) else $error("likely flag wrong");
  a_offset: assert property (p_offset) else $error("offset shift wrong");
  a_no_ext: assert property (p_no_ext) else $error("extension flagged");
endmodule : isa_mode_chk

bind isa_mode_switch_control isa_mode_chk u_chk (.aclk, .aresetn, .enc_strap, .flow_event,
  .branch_likely, .offset, .cur_mode, .flow_result, .illegal_likely, .offset_bytes,
  .compression_ext_present_bit);

// >>> tb/test_isa_mode_switch_control.sv
// Self-checking bench for the instruction-set mode controller
`timescale 1ns/100ps

module test_isa_mode_switch_control;
  // ==========================================================================
  // Design signals
  logic aclk, cur_mode, illegal_likely, compression_ext_present_bit;
  logic aresetn = 1'b0, branch_likely = 1'b0, probe_wr, probe_mode;
  logic [1:0] enc_strap, s_axi_bresp, s_axi_rresp;
  logic exc_mode_strap, dbg_mode_strap;
  logic [25:0] offset = 26'h0;
  logic [31:0] offset_bytes, s_axi_rdata, s_axi_wdata = 32'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  isa_mode_pkg::flow_event_t flow_event = '0;
  isa_mode_pkg::flow_result_t flow_result;
  // Reference model state
  logic [1:0] enc, e;
  logic m_mode, m_dbg, m_exc[4];
  int m_last, n_checks, n_mismatch;
  logic [31:0] d;
  logic [1:0] r;
  logic [1:0] encs[4] = '{2'h2, 2'h3, 2'h0, 2'h1};

  isa_mode_switch_control dut (.aclk, .aresetn, .enc_strap, .exc_mode_strap, .dbg_mode_strap,
    .probe_wr, .probe_mode, .flow_event, .branch_likely, .offset, .cur_mode, .flow_result,
    .illegal_likely, .offset_bytes, .compression_ext_present_bit, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  strap_probe_model prt (.aclk, .enc_strap, .exc_mode_strap, .dbg_mode_strap, .probe_wr,
    .probe_mode);

  // 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ==========================================================================
  // Reporting
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Bus master: handshakes judged mid-cycle, away from the taking edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic hw, hd, hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    repeat (20) begin
      @(negedge aclk);
      hw = s_axi_awvalid && s_axi_awready;
      hd = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (hw) s_axi_awvalid <= 1'b0;
      if (hd) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
      if (hb) return;
    end
    n_mismatch++;
    report_and_stop();
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ha, hr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (20) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      hr = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
      if (hr) return;
    end
    n_mismatch++;
    report_and_stop();
  endtask : axi_rd

  // Reset with fresh straps; events wait until the straps are loaded
  task automatic do_reset(input logic [1:0] en);
    logic x;
    x = 1'($urandom);
    @(posedge aclk);
    aresetn <= 1'b0;
    prt.set_straps(en, x, !x);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    enc = en;
    m_mode = en[0];
    m_dbg = !x;
    m_last = 0;
    foreach (m_exc[i]) m_exc[i] = x;
    #1;
    chk("reset_mode", cur_mode, m_mode);
  endtask : do_reset

  // One pipeline event, checked just after the edge that takes it
  task automatic ev(input logic [2:0] k, input logic [1:0] el, input logic [31:0] s);
    logic om, ra, ad, jmp;
    logic [31:0] ob;
    om = m_mode;
    jmp = (k == 3'h1 || k == 3'h2);
    ra = (k == 3'h3 && !enc[1]);
    ad = jmp && !enc[1] && s[0] != om;
    @(posedge aclk);
    flow_event <= {1'b1, k, el, s};
    branch_likely <= 1'($urandom);
    offset <= 26'($urandom);
    @(posedge aclk);
    flow_event.valid <= 1'b0;
    m_last = el;
    if (enc[1] && k == 3'h3) m_mode = !om;
    if (enc[1] && (jmp || k == 3'h7)) m_mode = s[0];
    if (enc[1] && (k == 3'h4 || k == 3'h6)) m_mode = m_exc[el];
    if (enc[1] && k == 3'h5) m_mode = m_dbg;
    #1;
    ob = {{6{offset[25]}}, offset} << (m_mode ? 1 : 2);
    chk("mode", cur_mode, m_mode);
    chk("resv", flow_result.resv_instr, ra);
    chk("addr_exc", flow_result.addr_exc, ad);
    if (jmp && !ad) chk("pc", flow_result.pc, s & 32'hFFFFFFFE);
    if (k == 3'h2 && !ad) chk("link", flow_result.link_bit0, om);
    if (k[2] && k != 3'h7) chk("save", flow_result.save_bit0, om);
    chk("offset", offset_bytes, ob);
    chk("likely", illegal_likely, branch_likely && m_mode);
  endtask : ev

  // ==========================================================================
  // Main sequence: every encoding strap, random traffic, then register and probe work for the dual-encoding straps
  initial begin
    void'($urandom(32'hD483EC37));
    foreach (encs[j]) begin
      do_reset(encs[j]);
      axi_rd(isa_mode_pkg::CFG_ADDR, d, r);
      chk("cfg_enc", d & 32'h0000C000, {16'h0, enc, 14'h0});
      if (enc[1]) chk("cfg_exc", d[16], m_exc[m_last]);
      repeat (20) ev(3'($urandom_range(1, 7)), 2'($urandom), $urandom);
      chk("ext", compression_ext_present_bit, 32'h0);
      if (enc[1]) begin
        axi_wr(isa_mode_pkg::CFG_ADDR, {15'h0, 1'b1, ~enc, 14'h0}, r);
        m_exc[m_last] = 1'b1;
        e = 2'(m_last);
        axi_rd(isa_mode_pkg::CFG_ADDR, d, r);
        chk("cfg_ro", d & 32'h0001C000, {15'h0, 1'b1, enc, 14'h0});
        ev(3'h4, e + 2'h1, 32'h0);
        ev(3'h6, e, 32'h0);
        chk("elem_mode", cur_mode, 32'h1);
        axi_rd(isa_mode_pkg::STATUS_ADDR, d, r);
        chk("last_elem", d[1:0], e);
        prt.probe_write(!m_dbg);
        m_dbg = !m_dbg;
        axi_rd(isa_mode_pkg::DBG_CTRL_ADDR, d, r);
        chk("dbg_sel", d[0], m_dbg);
        ev(3'h5, e, 32'h0);
        chk("dbg_mode", cur_mode, m_dbg);
        axi_wr(8'h0C, 32'hFFFFFFFF, r);
        chk("wr_resp", r, isa_mode_pkg::RESP_SLVERR);
        axi_rd(8'h0C, d, r);
        chk("rd_bad", {r, d[29:0]}, {isa_mode_pkg::RESP_SLVERR, 30'h0});
      end
      $display("test for encoding %0d done", enc);
    end
    report_and_stop();
  end
endmodule : test_isa_mode_switch_control
